// File: logic/qdac_pkg.sv
// Package of the quad converter serial control block.
// Assumes a single system clock; all pins are sampled by the block itself.
package qdac_pkg;

   // ************************************************************
   // Word layout
   // ************************************************************
   localparam int WORD_BITS = 12;
   localparam int DATA_BITS = 8;
   localparam int NUM_CHAN = 4;
   localparam int SHIFT_DEPTH = 12;
   localparam int ADDR_HI_POS = 11;
   localparam int ADDR_LO_POS = 10;
   localparam int CTRL_HI_POS = 9;
   localparam int CTRL_LO_POS = 8;
   localparam int DATA_MSB_POS = 7;
   localparam int SYNC_STAGES = 2;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic [11:0] SHIFT_RST = 12'h000;
   localparam logic USER_OUT_RST = 1'b0;
   localparam logic DOUT_RST = 1'b0;

   // ************************************************************
   // Commands: address pair then control pair
   // ************************************************************
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_USER_LOW = 4'h2;
   localparam logic [3:0] OP_SW_LOAD = 4'h4;
   localparam logic [3:0] OP_USER_HIGH = 4'h6;
   localparam logic [3:0] OP_LOAD_ALL = 4'h8;
   localparam logic [3:0] OP_EDGE_FALL = 4'hA;
   localparam logic [3:0] OP_SHUTDOWN = 4'hC;
   localparam logic [3:0] OP_EDGE_RISE = 4'hE;
   localparam logic [1:0] CTRL_INPUT_ONLY = 2'h1;
   localparam logic [1:0] CTRL_INPUT_UPD = 2'h3;

   typedef enum logic [0:0] {
      QDAC_LAUNCH_FALL = 1'b0,
      QDAC_LAUNCH_RISE = 1'b1
   } qdac_launch_t;

   typedef struct packed {
      logic chan_addr_hi;
      logic chan_addr_lo;
      logic ctrl_bit_hi;
      logic ctrl_bit_lo;
      logic [7:0] data;
   } qdac_word_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } qdac_serial_t;

endpackage : qdac_pkg

// File: logic/qdac_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs may change at any time relative to clk_sys.
module qdac_sync
   import qdac_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Pins
   input wire logic [4:0] pin_in,
   output logic [4:0] pin_sync
);

   logic [4:0] meta_reg;
   logic [4:0] sync_reg;

   // Reset state: strobes idle high, sclk and din low (sclk,cs_n,din,load_dac_n_n,clr_n)
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_reg <= 5'h0B;
         sync_reg <= 5'h0B;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   assign pin_sync = sync_reg;

endmodule : qdac_sync

// File: logic/qdac_shift.sv
// Twelve-stage serial shift register with delayed serial output.
// Assumes shift_en and launch strobes come from edge detection on clk_sys.
module qdac_shift
   import qdac_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Control
   input wire logic shift_en,
   input wire logic launch_en,
   input wire logic din,
   // State
   output logic [11:0] word,
   output logic dout
);

   logic [11:0] word_reg;
   logic dout_reg;

   // Captures on sclk rise; older bits fall off the top so only last 12 stay
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         word_reg <= SHIFT_RST;
      end else if (shift_en) begin
         word_reg <= {word_reg[10:0], din};
      end
   end

   // Holds its value between launches, so never floats
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dout_reg <= DOUT_RST;
      end else if (launch_en) begin
         dout_reg <= word_reg[11];
      end
   end

   assign word = word_reg;
   assign dout = dout_reg;

endmodule : qdac_shift

// File: logic/qdac_ctrl.sv
// Top of the quad converter serial control block.
// Assumes sclk, cs_n, din, load_dac_n and clear_n are pins asynchronous
// to clk_sys; sclk must be slower than a quarter of clk_sys.

// Function
// - Reset clears shifter and all codes
// - Output launches on falling edge after reset
// - MSB first; 4+8 or 12 same
// - Sixteen bits: keep last twelve only
// - Output shifts while input shifts
// - Serial output always driven
// - Capture input on rising edge, select low
// - Output delayed twelve clocks, selected edge
// - Select high: ignore clock, hold output
// - Decode only on select rising
// - Load low copies input to converter
// - Clear low zeroes all code registers
// - Shutdown only with enable high
// - Address, control, eight data bits
// - Both address ones with control 10 select rising launch
// - Code 01 input, 11 input plus update
// - 0100 update all, 1000 load all
// - Shutdown, user low/high, no-op commands
// - 1110 rising, 1010 falling, plus update
module qdac_ctrl
   import qdac_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   // Control pins
   input wire logic load_dac_n,
   input wire logic clear_n,
   input wire logic powerdown_enable,
   output logic user_logic_out,
   // Converter state
   output logic [7:0] dac_code_a,
   output logic [7:0] dac_code_b,
   output logic [7:0] dac_code_c,
   output logic [7:0] dac_code_d,
   output logic shutdown
);

   // ************************************************************
   // Pin sampling
   // ************************************************************
   logic [4:0] pin_sync;
   qdac_serial_t ser;
   logic load_n_s;
   logic clear_n_s;
   logic pde_meta_reg;
   logic pde_reg;

   qdac_sync u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin_in({sclk, cs_n, din, load_dac_n, clear_n}),
      .pin_sync(pin_sync)
   );

   assign ser = qdac_serial_t'(pin_sync[4:2]);
   assign load_n_s = pin_sync[1];
   assign clear_n_s = pin_sync[0];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pde_meta_reg <= 1'b0;
         pde_reg <= 1'b0;
      end else begin
         pde_meta_reg <= powerdown_enable;
         pde_reg <= pde_meta_reg;
      end
   end

   // ************************************************************
   // Edge detection
   // ************************************************************
   logic sclk_d_reg;
   logic cs_n_d_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sclk_d_reg <= 1'b0;
         cs_n_d_reg <= 1'b1;
      end else begin
         sclk_d_reg <= ser.sclk;
         cs_n_d_reg <= ser.cs_n;
      end
   end

   // Select high masks both edges so the clock is ignored
   assign sclk_rise = ser.sclk && !sclk_d_reg && !ser.cs_n;
   assign sclk_fall = !ser.sclk && sclk_d_reg && !ser.cs_n;
   assign cs_rise = ser.cs_n && !cs_n_d_reg;

   // ************************************************************
   // Shift path
   // ************************************************************
   qdac_launch_t launch_reg;
   logic launch_en;
   logic [11:0] shift_word;
   qdac_word_t cmd;

   // Output stage samples the top bit before the shift lands, giving the
   // twelve-clock delay on either edge
   assign launch_en = (launch_reg == QDAC_LAUNCH_RISE) ? sclk_rise : sclk_fall;

   qdac_shift u_shift (
      .clk_sys(clk_sys),
      .srst(srst),
      .shift_en(sclk_rise),
      .launch_en(launch_en),
      .din(ser.din),
      .word(shift_word),
      .dout(dout)
   );

   assign cmd = qdac_word_t'(shift_word);

   // ************************************************************
   // Decode
   // ************************************************************
   logic [3:0] op;
   logic [1:0] chan;
   logic ld_input;
   logic upd_all;
   logic ld_all;
   logic sd_set;
   logic sd_clr;

   function automatic logic is_op(input logic [3:0] code, input logic [3:0] want);
      is_op = (code == want);
   endfunction : is_op

   assign op = {cmd.chan_addr_hi, cmd.chan_addr_lo, cmd.ctrl_bit_hi, cmd.ctrl_bit_lo};
   assign chan = {cmd.chan_addr_hi, cmd.chan_addr_lo};

   // Commands act only on select rising; nop matches nothing here
   assign ld_input = cs_rise && (op[1:0] == CTRL_INPUT_ONLY
      || op[1:0] == CTRL_INPUT_UPD);
   assign upd_all = cs_rise && (op[1:0] == CTRL_INPUT_UPD || is_op(op, OP_SW_LOAD)
      || is_op(op, OP_EDGE_RISE) || is_op(op, OP_EDGE_FALL));
   assign ld_all = cs_rise && is_op(op, OP_LOAD_ALL);
   assign sd_set = cs_rise && is_op(op, OP_SHUTDOWN) && pde_reg;
   assign sd_clr = cs_rise && (is_op(op, OP_SW_LOAD) || is_op(op, OP_LOAD_ALL));

   // ************************************************************
   // Channel registers
   // ************************************************************
   logic [7:0] in_reg [NUM_CHAN];
   logic [7:0] dac_reg [NUM_CHAN];

   // Clear pin wins over every load; it is sampled, so "immediate" means
   // within the synchroniser latency
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (srst || !clear_n_s) begin
            in_reg[i] <= CODE_RST;
         end else if (ld_input && chan == 2'(i)) begin
            in_reg[i] <= cmd.data;
         end
      end
   end

   // Input-plus-update takes the fresh byte for the addressed channel
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (srst || !clear_n_s) begin
            dac_reg[i] <= CODE_RST;
         end else if (ld_all) begin
            dac_reg[i] <= cmd.data;
         end else if (upd_all && op[1:0] == CTRL_INPUT_UPD && chan == 2'(i)) begin
            dac_reg[i] <= cmd.data;
         end else if (upd_all || !load_n_s) begin
            dac_reg[i] <= in_reg[i];
         end
      end
   end

   // ************************************************************
   // Mode, shutdown and user output
   // ************************************************************
   logic shutdown_reg;
   logic user_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         launch_reg <= QDAC_LAUNCH_FALL;
      end else if (cs_rise && is_op(op, OP_EDGE_RISE)) begin
         launch_reg <= QDAC_LAUNCH_RISE;
      end else if (cs_rise && is_op(op, OP_EDGE_FALL)) begin
         launch_reg <= QDAC_LAUNCH_FALL;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || !clear_n_s) begin
         shutdown_reg <= 1'b0;
      end else if (sd_set) begin
         shutdown_reg <= 1'b1;
      end else if (sd_clr) begin
         shutdown_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || !clear_n_s) begin
         user_reg <= USER_OUT_RST;
      end else if (cs_rise && is_op(op, OP_USER_LOW)) begin
         user_reg <= 1'b0;
      end else if (cs_rise && is_op(op, OP_USER_HIGH)) begin
         user_reg <= 1'b1;
      end
   end

   assign user_logic_out = user_reg;
   assign shutdown = shutdown_reg;
   assign dac_code_a = dac_reg[0];
   assign dac_code_b = dac_reg[1];
   assign dac_code_c = dac_reg[2];
   assign dac_code_d = dac_reg[3];

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   rst_launch_a: assert property ($fell(srst) |-> launch_reg == QDAC_LAUNCH_FALL)
      else $error("launch edge not falling after reset");
   hold_dout_a: assert property (ser.cs_n && $past(ser.cs_n) |-> $stable(dout))
      else $error("dout moved while select high");
   shift_only_a: assert property (!sclk_rise |=> $stable(shift_word))
      else $error("shift register moved without clock rise");
   decode_cs_a: assert property (!cs_rise && clear_n_s && load_n_s
      |=> $stable(user_reg) && $stable(launch_reg))
      else $error("command acted without select rise");
   clear_zero_a: assert property (!clear_n_s |=> dac_reg[0] == CODE_RST
      && in_reg[3] == CODE_RST)
      else $error("clear did not zero registers");
   load_copy_a: assert property (!load_n_s && clear_n_s && !cs_rise
      |=> dac_reg[2] == $past(in_reg[2]))
      else $error("load pin did not copy input register");
   pde_gate_a: assert property (cs_rise && is_op(op, OP_SHUTDOWN) && !pde_reg
      && !shutdown_reg && clear_n_s |=> !shutdown_reg)
      else $error("shutdown entered without enable");
   edge_rise_a: assert property (cs_rise && is_op(op, OP_EDGE_RISE)
      |=> launch_reg == QDAC_LAUNCH_RISE)
      else $error("rising launch not selected");
   user_high_a: assert property (cs_rise && is_op(op, OP_USER_HIGH) && clear_n_s
      |=> user_logic_out)
      else $error("user output not raised");
   load_all_a: assert property (ld_all && clear_n_s
      |=> dac_reg[1] == $past(cmd.data) && !shutdown_reg)
      else $error("load all failed");
   edge_fall_a: assert property (cs_rise && is_op(op, OP_EDGE_FALL)
      |=> launch_reg == QDAC_LAUNCH_FALL)
      else $error("falling launch not selected");
   user_low_a: assert property (cs_rise && is_op(op, OP_USER_LOW) && clear_n_s
      |=> !user_logic_out)
      else $error("user output not lowered");
   sw_load_a: assert property (cs_rise && is_op(op, OP_SW_LOAD) && clear_n_s
      |=> dac_reg[0] == $past(in_reg[0]) && !shutdown_reg)
      else $error("software load failed");
   in_load_a: assert property (ld_input && chan == 2'h1 && clear_n_s
      |=> in_reg[1] == $past(cmd.data))
      else $error("input register not loaded");
   dac_keep_a: assert property (ld_input && op[1:0] == CTRL_INPUT_ONLY
      && clear_n_s && load_n_s |=> $stable(dac_reg[0]) && $stable(dac_reg[3]))
      else $error("input-only command moved a converter register");
   upd_direct_a: assert property (ld_input && op[1:0] == CTRL_INPUT_UPD
      && chan == 2'h3 && clear_n_s |=> dac_reg[3] == $past(cmd.data))
      else $error("input plus update missed the converter register");
   shut_set_a: assert property (cs_rise && is_op(op, OP_SHUTDOWN) && pde_reg
      && clear_n_s |=> shutdown_reg)
      else $error("enabled shutdown not entered");
   nop_keep_a: assert property (cs_rise && is_op(op, OP_NOP) && clear_n_s
      && load_n_s |=> $stable(dac_reg[1]) && $stable(in_reg[1]) && $stable(shutdown_reg))
      else $error("no-op command changed a register");
   dout_delay_a: assert property (launch_en
      |=> dout == $past(shift_word[11]))
      else $error("serial output not taken from top of shifter");
   shift_cap_a: assert property (sclk_rise
      |=> shift_word[0] == $past(ser.din))
      else $error("serial input not captured on clock rise");

   cov_shutdown_c: cover property (sd_set);
   cov_rise_mode_c: cover property (launch_reg == QDAC_LAUNCH_RISE && sclk_rise);
   cov_ld_input_c: cover property (ld_input);
   cov_load_pin_c: cover property (!load_n_s);
   cov_ld_all_c: cover property (ld_all);

endmodule : qdac_ctrl

// File: tb/qdac_master.sv
// Serial master model for the quad converter control block.
// Assumes the caller is just past a falling edge of clk_sys.
module qdac_master (
   // Clock
   input wire logic clk_sys,
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout,
   // Bits seen on the serial output
   output logic [11:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Frame driver
   // ************************************************************
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
      rx = 12'h000;
   end

   // Sel low toggles the clock with select held high
   task automatic send(input logic [15:0] w, input int n, input int pause, input logic sel);
      cs_n = ~sel;
      repeat (3) @(negedge clk_sys);
      for (int i = n - 1; i >= 0; i--) begin
         if (i == 7) repeat (pause) @(negedge clk_sys);
         din = w[i];
         repeat (4) @(negedge clk_sys);
         sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
         // Sampled late in the high phase, clear of launch latency
         rx = {rx[10:0], dout};
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      cs_n = 1'b1;
      // Released line must not keep the last bit
      din = ~din;
      repeat (8) @(negedge clk_sys);
   endtask : send
endmodule : qdac_master

// File: tb/qdac_ctrl_test.sv
// Self-checking bench of the quad converter serial control block.
// Assumes the master model owns the serial pins; the bench drives the rest.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module qdac_ctrl_test
   import qdac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, srst = 1'b1, load_dac_n = 1'b1, clear_n = 1'b1;
   logic powerdown_enable = 1'b0, chk = 1'b0, mode = 1'b0, was1 = 1'b0;
   logic sclk, cs_n, din, dout, user_logic_out, shutdown;
   logic user = 1'b0, shut = 1'b0;
   logic [7:0] dac_code_a, dac_code_b, dac_code_c, dac_code_d;
   logic [11:0] rx, e_mask, prev12 = 12'h000;
   logic [7:0] inr [4] = '{default: 8'h00};
   logic [7:0] dac [4] = '{default: 8'h00};
   logic [45:0] e_note;
   logic [45:0] notes [$];
   logic [11:0] masks [$];
   logic [31:0] lfsr_state = 32'hC2A3C9CF;
   int mismatches = 0, total_checks = 0, cycles = 0;

   qdac_ctrl DUT (.clk_sys(clk_sys), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .load_dac_n(load_dac_n), .clear_n(clear_n),
      .powerdown_enable(powerdown_enable), .user_logic_out(user_logic_out),
      .dac_code_a(dac_code_a), .dac_code_b(dac_code_b), .dac_code_c(dac_code_c),
      .dac_code_d(dac_code_d), .shutdown(shutdown));
   qdac_master M (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .rx(rx));

   // ************************************************************
   // Clock, timeout, verdict
   // ************************************************************
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         mismatches++;
         print_verdict();
      end
   end

   // ************************************************************
   // Expected-state model and notes
   // ************************************************************
   function automatic logic [7:0] rnd();
      lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
      return lfsr_state[7:0];
   endfunction : rnd

   task automatic apply(input logic [11:0] w);
      if (w[9:8] == CTRL_INPUT_ONLY || w[9:8] == CTRL_INPUT_UPD) inr[w[11:10]] = w[7:0];
      if (w[9:8] == CTRL_INPUT_UPD) dac = inr;
      case (w[11:8])
         OP_SW_LOAD, OP_EDGE_RISE, OP_EDGE_FALL: dac = inr;
         OP_LOAD_ALL: dac = '{default: w[7:0]};
         OP_SHUTDOWN: shut = shut | powerdown_enable;
         OP_USER_LOW: user = 1'b0;
         OP_USER_HIGH: user = 1'b1;
         default: ;
      endcase
      if (w[11:8] == OP_SW_LOAD || w[11:8] == OP_LOAD_ALL) shut = 1'b0;
      if (w[11:8] == OP_EDGE_RISE) mode = QDAC_LAUNCH_RISE;
      if (w[11:8] == OP_EDGE_FALL) mode = QDAC_LAUNCH_FALL;
   endtask : apply

   task automatic note(input logic [11:0] m);
      notes.push_back({prev12, dac[0], dac[1], dac[2], dac[3], user, shut});
      masks.push_back(m);
      chk = 1'b1;
      @(negedge clk_sys);
      chk = 1'b0;
   endtask : note

   // Output bits are judged in every selected twelve-bit frame; after a switch back to
   // falling launch the first bit still shows the last rising launch, so it is skipped
   task automatic frame(input logic [15:0] w, input int n, input int pause, input logic sel);
      logic [11:0] m;
      m = (n == 12 && sel) ? ((was1 && !mode) ? 12'h7FF : 12'hFFF) : 12'h000;
      was1 = mode;
      M.send(w, n, pause, sel);
      if (sel) apply(w[11:0]);
      note(m);
      if (sel) prev12 = w[11:0];
   endtask : frame

   always @(posedge clk_sys) begin
      if (chk === 1'b1 && notes.size() > 0) begin
         e_note = notes.pop_front();
         e_mask = masks.pop_front();
         `CHK(rx & e_mask, e_note[45:34] & e_mask)
         `CHK({dac_code_a, dac_code_b, dac_code_c, dac_code_d, user_logic_out, shutdown},
            e_note[33:0])
      end
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      repeat (10) @(negedge clk_sys);
      srst = 1'b0;
      repeat (4) @(negedge clk_sys);
      note(12'h000);
      for (int k = 0; k < 3; k++) frame({4'h0, 2'(k), CTRL_INPUT_ONLY, rnd()}, 12, 0, 1'b1);
      frame({6'h03, CTRL_INPUT_UPD, rnd()}, 12, 20, 1'b1);
      $display("test input registers done");
      frame({4'hC, OP_LOAD_ALL, rnd()}, 16, 0, 1'b1);
      frame({4'h0, OP_NOP, 8'h55}, 12, 0, 1'b1);
      frame({4'h0, OP_SHUTDOWN, rnd()}, 12, 0, 1'b1);
      powerdown_enable = 1'b1;
      frame({4'h0, OP_SHUTDOWN, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_SW_LOAD, rnd()}, 12, 0, 1'b1);
      $display("test shutdown done");
      frame({4'h0, OP_USER_HIGH, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_USER_LOW, 8'hFF}, 12, 0, 1'b0);
      frame({4'h0, OP_NOP, rnd()}, 12, 0, 1'b1);
      frame({4'h0, 2'h1, CTRL_INPUT_ONLY, rnd()}, 12, 0, 1'b1);
      load_dac_n = 1'b0;
      repeat (6) @(negedge clk_sys);
      dac = inr;
      note(12'h000);
      load_dac_n = 1'b1;
      $display("test load and select done");
      frame({4'h0, 2'h2, CTRL_INPUT_ONLY, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_EDGE_RISE, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_NOP, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_EDGE_FALL, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_USER_LOW, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_NOP, rnd()}, 12, 0, 1'b1);
      $display("test launch edge done");
      frame({4'h0, OP_SHUTDOWN, rnd()}, 12, 0, 1'b1);
      frame({4'h0, OP_USER_HIGH, rnd()}, 12, 0, 1'b1);
      clear_n = 1'b0;
      repeat (6) @(negedge clk_sys);
      inr = '{default: 8'h00};
      dac = '{default: 8'h00};
      user = 1'b0;
      shut = 1'b0;
      note(12'h000);
      clear_n = 1'b1;
      frame({4'h0, OP_SW_LOAD, rnd()}, 12, 0, 1'b1);
      $display("test clear done");
      print_verdict();
   end
endmodule : qdac_ctrl_test
